// *** mcq_pkg.sv ***
// constants for the motion capture and quadrature block
// assumes a single 100 MHz clock and an AXI4-Lite register port
package mcq_pkg;
    // ==========================================
    // bus and register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CAP_CTRL = 8'h00;
    localparam logic [7:0] OFF_TB_CTRL = 8'h04;
    localparam logic [7:0] OFF_TB_COUNT = 8'h08;
    localparam logic [7:0] OFF_CAP_BUF0 = 8'h0c;
    localparam logic [7:0] OFF_QEI_CTRL = 8'h18;
    localparam logic [7:0] OFF_POS_COUNT = 8'h1c;
    localparam logic [7:0] OFF_POS_LIMIT = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h28;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h2c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // field positions and reset values
    localparam int CAP_REN_LSB = 16;
    localparam int TB_RUN_BIT = 0;
    localparam int TB_SEVT_BIT = 1;
    localparam int QEI_DIR_BIT = 5;
    localparam int IRQ_POS_BIT = 3;
    localparam logic [15:0] POS_LIMIT_RST = 16'hffff;
    // ==========================================
    // capture mode codes
    localparam logic [3:0] CM_OFF = 4'h0;
    localparam logic [3:0] CM_RISE = 4'h1;
    localparam logic [3:0] CM_FALL = 4'h2;
    localparam logic [3:0] CM_BOTH = 4'h3;
    localparam logic [3:0] CM_RISE_B = 4'h4;
    localparam logic [3:0] CM_PERIOD = 4'h5;
    localparam logic [3:0] CM_PW_HI = 4'h6;
    localparam logic [3:0] CM_PW_LO = 4'h7;
    localparam logic [3:0] CM_STATE = 4'h8;
    localparam logic [3:0] CM_TRIG_R = 4'he;
    localparam logic [3:0] CM_TRIG_F = 4'hf;
    // decoder mode codes
    localparam logic [2:0] QM_OFF = 3'h0;
    localparam logic [2:0] QM_X2_IDX = 3'h1;
    localparam logic [2:0] QM_X2_MAT = 3'h2;
    localparam logic [2:0] QM_X4_IDX = 3'h5;
    localparam logic [2:0] QM_X4_MAT = 3'h6;
    // quarter-cycle phases, one clock each
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b10, PH_Q4 = 2'b11
    } mcq_phase_type;
endpackage : mcq_pkg

// *** mcq_top.sv ***
// capture channels on a shared time base plus a quadrature decoder
// assumes pins are asynchronous; registers over AXI4-Lite
//
// Behaviour
// [RL1] first active edge stores time base in buffer
// [RL2] every later active edge records time base
// [RL3] reset enable clears time base after capture
// [RL4] pulse-width modes ignore the reset enable
// [RL5] capture repeats until mode changed or reset
// [RL6] mode switching leaves time base unchanged
// [RL7] capture modes set the channel interrupt flag
// [RL8] channel one trigger mode: no flag, trigger
// [RL9] edge sampled at Q2, acted on at Q4
// [RL10] enabled trigger resets base, sets run at Q1
// [RL11] decoder mode zero and unused codes disable all
// [RL12] x2 mode counts phase A edges only
// [RL13] x4 mode counts both phase edges
// [RL14] index or limit match resets position count
// [RL15] direction bit set when A leads B
// [RL16] edge order decides up or down count
// [RL17] all pins pass a two-stage synchroniser
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module mcq_top #(
    parameter int NUM_CH = 3
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [mcq_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [mcq_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [NUM_CH-1:0] CAPTURE_INPUT_I,
    input wire logic PHASE_A_INPUT_I,
    input wire logic PHASE_B_INPUT_I,
    input wire logic INDEX_INPUT_I,
    output logic SPECIAL_EVENT_O,
    output logic IRQ_O
);
    import mcq_pkg::*;
    localparam int SW = NUM_CH + 3;
    localparam int IW = NUM_CH + 1;

    // ==========================================
    // state
    mcq_phase_type phase_q, phase_d;
    logic [SW-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic [2:0] qe_prev_q, qe_prev_d;
    logic [NUM_CH-1:0] cap_smp_q, cap_smp_d, cap_prv_q, cap_prv_d;
    logic [3:0] cap_mode_q [NUM_CH], cap_mode_d [NUM_CH];
    logic [NUM_CH-1:0] cap_ren_q, cap_ren_d;
    logic [15:0] cap_buf_q [NUM_CH], cap_buf_d [NUM_CH];
    logic [15:0] tb_q, tb_d, pos_q, pos_d, lim_q, lim_d;
    logic tb_run_q, tb_run_d, sevt_en_q, sevt_en_d;
    logic sevt_pend_q, sevt_pend_d, sevt_out_q, sevt_out_d;
    logic [2:0] qei_mode_q, qei_mode_d;
    logic dir_q, dir_d;
    logic [IW-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // ==========================================
    // combinational helpers
    logic [NUM_CH-1:0] cap_hit, cap_clr, cap_trig;
    logic wr_go, rd_go, qa, qb, qi, a_edge, b_edge, qe_en, qe_cnt;
    logic qe_up, idx_rst, mat_rst;
    logic [31:0] cap_ctrl_view, wmask;
    logic [ADDR_W-1:0] waddr, raddr;

    // ==========================================
    // bus handshakes; writes taken once both write channels are offered, reads on the read address alone
    assign wr_go = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~bvalid_q;
    assign rd_go = S_AXI_ARVALID_I & ~rvalid_q;
    assign S_AXI_AWREADY_O = wr_go;
    assign S_AXI_WREADY_O = wr_go;
    assign S_AXI_ARREADY_O = rd_go;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign SPECIAL_EVENT_O = sevt_out_q;
    assign IRQ_O = |(irq_stat_q & irq_en_q);
    assign waddr = {S_AXI_AWADDR_I[ADDR_W-1:2], 2'b00};
    assign raddr = {S_AXI_ARADDR_I[ADDR_W-1:2], 2'b00};
    assign wmask = {{8{S_AXI_WSTRB_I[3]}}, {8{S_AXI_WSTRB_I[2]}},
                    {8{S_AXI_WSTRB_I[1]}}, {8{S_AXI_WSTRB_I[0]}}};

    // synchronised pins: caps low, then a, b, index
    assign qa = sync2_q[NUM_CH];
    assign qb = sync2_q[NUM_CH+1];
    assign qi = sync2_q[NUM_CH+2];

    // ==========================================
    // capture edge decode, acted on in Q4 only
    always_comb begin
        logic rise, fall;
        rise = 1'b0;
        fall = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            rise = cap_smp_q[i] & ~cap_prv_q[i];
            fall = ~cap_smp_q[i] & cap_prv_q[i];
            cap_hit[i] = 1'b0;
            cap_clr[i] = 1'b0;
            cap_trig[i] = 1'b0;
            case (cap_mode_q[i])
                CM_RISE, CM_RISE_B, CM_PERIOD: cap_hit[i] = rise;
                CM_FALL: cap_hit[i] = fall;
                CM_BOTH, CM_STATE: cap_hit[i] = rise | fall;
                CM_PW_HI: begin
                    cap_hit[i] = fall;
                    cap_clr[i] = rise; // see RL4
                end
                CM_PW_LO: begin
                    cap_hit[i] = rise;
                    cap_clr[i] = fall; // see RL4
                end
                CM_TRIG_R: cap_trig[i] = (i == 0) & rise; // see RL8
                CM_TRIG_F: cap_trig[i] = (i == 0) & fall; // see RL8
                default: cap_hit[i] = 1'b0;
            endcase
            if (cap_mode_q[i] != CM_PW_HI && cap_mode_q[i] != CM_PW_LO) begin
                cap_clr[i] = (cap_hit[i] | cap_trig[i]) & cap_ren_q[i];
            end // see RL3
            if (phase_q != PH_Q4) begin // see RL9
                cap_hit[i] = 1'b0;
                cap_clr[i] = 1'b0;
                cap_trig[i] = 1'b0;
            end
        end
    end

    // ==========================================
    // decoder edge and direction decode
    assign a_edge = qa ^ qe_prev_q[0];
    assign b_edge = qb ^ qe_prev_q[1];
    assign qe_en = (qei_mode_q == QM_X2_IDX) | (qei_mode_q == QM_X2_MAT) |
                   (qei_mode_q == QM_X4_IDX) | (qei_mode_q == QM_X4_MAT);
    // see RL11, RL12, RL13
    assign qe_cnt = qe_en & (a_edge | (qei_mode_q[2] & b_edge));
    assign qe_up = a_edge ? (qa ^ qb) : ~(qa ^ qb); // see RL16
    assign idx_rst = qe_en & qei_mode_q[0] & qi & ~qe_prev_q[2];
    assign mat_rst = qe_cnt & qe_up & ~qei_mode_q[0] & (pos_q == lim_q);

    // control register viewed as one word
    always_comb begin
        cap_ctrl_view = 32'h0000_0000;
        for (int i = 0; i < NUM_CH; i++) begin
            cap_ctrl_view[4*i +: 4] = cap_mode_q[i];
            cap_ctrl_view[CAP_REN_LSB+i] = cap_ren_q[i];
        end
    end

    // ==========================================
    // next-state logic for the whole block
    always_comb begin
        logic [31:0] wv;
        logic [IW-1:0] irq_set, irq_clr;
        wv = (cap_ctrl_view & ~wmask) | (S_AXI_WDATA_I & wmask);
        irq_set = '0;
        irq_clr = '0;
        phase_d = mcq_phase_type'(phase_q + 2'h1);
        sync1_d = {INDEX_INPUT_I, PHASE_B_INPUT_I, PHASE_A_INPUT_I,
                   CAPTURE_INPUT_I}; // see RL17
        sync2_d = sync1_q;
        qe_prev_d = {qi, qb, qa};
        cap_smp_d = cap_smp_q;
        cap_prv_d = cap_prv_q;
        if (phase_q == PH_Q2) begin // see RL9
            cap_smp_d = sync2_q[NUM_CH-1:0];
            cap_prv_d = cap_smp_q;
        end
        cap_mode_d = cap_mode_q;
        cap_ren_d = cap_ren_q;
        cap_buf_d = cap_buf_q;
        tb_d = tb_q;
        tb_run_d = tb_run_q;
        sevt_en_d = sevt_en_q;
        sevt_pend_d = sevt_pend_q;
        sevt_out_d = 1'b0;
        qei_mode_d = qei_mode_q;
        lim_d = lim_q;
        irq_en_d = irq_en_q;
        pos_d = pos_q;
        dir_d = dir_q;
        bvalid_d = bvalid_q & ~S_AXI_BREADY_I;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q & ~S_AXI_RREADY_I;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        // capture store and flags
        for (int i = 0; i < NUM_CH; i++) begin
            if (cap_hit[i] | cap_trig[i]) begin
                cap_buf_d[i] = tb_q; // see RL1, RL2, RL5
            end
            irq_set[i] = cap_hit[i]; // see RL7, RL8
        end
        // time base: runs on Q1, capture clears in Q4, mode writes never
        if (|cap_clr) begin
            tb_d = 16'h0000; // see RL3, RL6
        end else if (phase_q == PH_Q1 && sevt_pend_q) begin
            tb_d = 16'h0000; // see RL10
            tb_run_d = 1'b1;
            sevt_pend_d = 1'b0;
        end else if (phase_q == PH_Q1 && tb_run_q) begin
            tb_d = tb_q + 16'h0001;
        end
        if (cap_trig[0]) begin
            sevt_out_d = 1'b1; // see RL8
            sevt_pend_d = sevt_en_q; // see RL10
        end
        // position counter
        if (idx_rst) begin
            pos_d = 16'h0000; // see RL14
        end else if (qe_cnt) begin
            dir_d = qe_up; // see RL15
            if (mat_rst) begin
                pos_d = 16'h0000; // see RL14
            end else if (qe_up) begin
                pos_d = pos_q + 16'h0001;
            end else if (~qei_mode_q[0] && pos_q == 16'h0000) begin
                pos_d = lim_q;
            end else begin
                pos_d = pos_q - 16'h0001;
            end
        end
        irq_set[IRQ_POS_BIT] = idx_rst | mat_rst;
        // register writes
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            unique case (waddr)
                OFF_CAP_CTRL: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        cap_mode_d[i] = wv[4*i +: 4];
                        cap_ren_d[i] = wv[CAP_REN_LSB+i];
                    end
                end
                OFF_TB_CTRL: begin
                    if (S_AXI_WSTRB_I[0]) begin
                        tb_run_d = S_AXI_WDATA_I[TB_RUN_BIT] |
                                   (tb_run_d & ~tb_run_q);
                        sevt_en_d = S_AXI_WDATA_I[TB_SEVT_BIT];
                    end
                end
                OFF_QEI_CTRL: begin
                    if (S_AXI_WSTRB_I[0]) begin
                        qei_mode_d = S_AXI_WDATA_I[2:0];
                    end
                end
                OFF_POS_LIMIT: lim_d = (lim_q & ~wmask[15:0]) |
                    (S_AXI_WDATA_I[15:0] & wmask[15:0]);
                OFF_IRQ_CLEAR: irq_clr = S_AXI_WDATA_I[IW-1:0];
                OFF_IRQ_ENABLE: irq_en_d = S_AXI_WDATA_I[IW-1:0];
                OFF_TB_COUNT, OFF_POS_COUNT, OFF_IRQ_STATUS: ;
                default: begin
                    if (waddr < OFF_CAP_BUF0 ||
                        waddr >= OFF_CAP_BUF0 + 8'(4*NUM_CH)) begin
                        bresp_d = RESP_SLVERR;
                    end
                end
            endcase
        end
        // set wins over a clear in the same cycle
        irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
        // register reads
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (raddr)
                OFF_CAP_CTRL: rdata_d = cap_ctrl_view;
                OFF_TB_CTRL: rdata_d = {30'h0, sevt_en_q, tb_run_q};
                OFF_TB_COUNT: rdata_d = {16'h0, tb_q};
                OFF_QEI_CTRL: rdata_d = {26'h0, dir_q, 2'h0, qei_mode_q};
                OFF_POS_COUNT: rdata_d = {16'h0, pos_q};
                OFF_POS_LIMIT: rdata_d = {16'h0, lim_q};
                OFF_IRQ_STATUS: rdata_d[IW-1:0] = irq_stat_q;
                OFF_IRQ_ENABLE: rdata_d[IW-1:0] = irq_en_q;
                OFF_IRQ_CLEAR: rdata_d = 32'h0000_0000;
                default: begin
                    rresp_d = RESP_SLVERR;
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (raddr == OFF_CAP_BUF0 + 8'(4*i)) begin
                            rdata_d = {16'h0, cap_buf_q[i]};
                            rresp_d = RESP_OKAY;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================
    // registers, synchronous active-low reset
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            phase_q <= PH_Q1;
            sync1_q <= '0;
            sync2_q <= '0;
            qe_prev_q <= 3'h0;
            cap_smp_q <= '0;
            cap_prv_q <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                cap_mode_q[i] <= CM_OFF;
                cap_buf_q[i] <= 16'h0000;
            end
            cap_ren_q <= '0;
            tb_q <= 16'h0000;
            tb_run_q <= 1'b0;
            sevt_en_q <= 1'b0;
            sevt_pend_q <= 1'b0;
            sevt_out_q <= 1'b0;
            qei_mode_q <= QM_OFF;
            dir_q <= 1'b0;
            pos_q <= 16'h0000;
            lim_q <= POS_LIMIT_RST;
            irq_stat_q <= '0;
            irq_en_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            phase_q <= phase_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            qe_prev_q <= qe_prev_d;
            cap_smp_q <= cap_smp_d;
            cap_prv_q <= cap_prv_d;
            cap_mode_q <= cap_mode_d;
            cap_buf_q <= cap_buf_d;
            cap_ren_q <= cap_ren_d;
            tb_q <= tb_d;
            tb_run_q <= tb_run_d;
            sevt_en_q <= sevt_en_d;
            sevt_pend_q <= sevt_pend_d;
            sevt_out_q <= sevt_out_d;
            qei_mode_q <= qei_mode_d;
            dir_q <= dir_d;
            pos_q <= pos_d;
            lim_q <= lim_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    chk_cap_store_value: assert property ( // see RL1
        cap_hit[0] |=> cap_buf_q[0] == $past(tb_q))
        else $error("capture buffer missed time base");
    chk_cap_clears_base: assert property ( // see RL3
        |cap_clr |=> tb_q == 16'h0000 ##4 tb_q <= 16'h0001)
        else $error("capture did not clear time base");
    chk_pw_ignores_ren: assert property ( // see RL4
        (cap_mode_q[0] == CM_PW_HI && cap_hit[0] &&
         cap_clr[NUM_CH-1:1] == '0)
        |=> tb_q == $past(tb_q))
        else $error("pulse width capture reset time base");
    chk_flag_on_capture: assert property ( // see RL7
        cap_hit[0] |=> irq_stat_q[0])
        else $error("capture flag not set");
    chk_trig_no_flag: assert property ( // see RL8
        (cap_trig[0] && !irq_stat_q[0]) |=> !irq_stat_q[0]
        && sevt_out_q)
        else $error("trigger mode set channel flag");
    chk_edge_in_q4: assert property ( // see RL9
        (|cap_hit || |cap_trig) |-> phase_q == PH_Q4)
        else $error("capture acted outside Q4");
    chk_trig_reset_q1: assert property ( // see RL10
        (cap_trig[0] && sevt_en_q) |=> ##1 tb_q == 16'h0000 && tb_run_q)
        else $error("trigger did not reset time base at Q1");
    chk_decoder_off: assert property ( // see RL11
        qei_mode_q == QM_OFF |=> pos_q == $past(pos_q))
        else $error("disabled decoder moved count");
    chk_x2_ignores_b: assert property ( // see RL12
        (qei_mode_q[2:1] == 2'b00 && !a_edge && !idx_rst)
        |=> pos_q == $past(pos_q))
        else $error("x2 mode counted a B edge");
    chk_count_up: assert property ( // see RL15
        (qe_cnt && qe_up && !mat_rst && !idx_rst)
        |=> pos_q == $past(pos_q) + 16'h0001 && dir_q)
        else $error("up count wrong");
    chk_index_reset: assert property ( // see RL14
        idx_rst |=> pos_q == 16'h0000)
        else $error("index did not reset count");

    cov_capture: cover property (cap_hit[0] ##1 irq_stat_q[0]);
    cov_trigger: cover property (cap_trig[0] && sevt_en_q);
    cov_x4_down: cover property (qe_cnt && !qe_up && qei_mode_q[2]);
    cov_match: cover property (mat_rst);
endmodule : mcq_top

// *** mcq_enc_model.sv ***
// model of the rotary encoder feeding the quadrature decoder pins
// assumes the bench asks for one step at a time, four or more clocks apart
`timescale 1ns/10ps
module mcq_enc_model (
    input wire logic clk_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic index_i,
    output logic phase_a_o,
    output logic phase_b_o,
    output logic index_o
);
    // ==========================================
    // shaft position as a two-bit binary step count
    logic [1:0] pos_q = 2'b00;

    // one phase moves per step; up runs 00,10,11,01 so phase a leads
    always_ff @(posedge clk_i) begin
        if (step_i) begin
            pos_q <= dir_i ? pos_q + 2'd1 : pos_q - 2'd1;
        end
    end

    // phase levels follow the shaft and index mark follows index_i at once
    assign phase_a_o = pos_q[1] ^ pos_q[0];
    assign phase_b_o = pos_q[1];
    assign index_o = index_i;
endmodule : mcq_enc_model

// *** mcq_top_tb.sv ***
// self-checking bench for the capture channels and quadrature decoder
// assumes mcq_pkg, mcq_top and mcq_enc_model are compiled first
`timescale 1ns/10ps
module mcq_top_tb;
    import mcq_pkg::*;
    // ==========================================
    // clock, bus and pin signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [2:0] cap = 3'h0;
    logic step = 1'b0;
    logic dir = 1'b0;
    logic idx = 1'b0;
    logic [31:0] rdata, rdv;
    logic [1:0] bresp, rresp, rsp;
    logic awready, wready, bvalid, arready, rvalid;
    logic pha, phb, pidx, sev, irq;
    int fail_count = 0;
    int num_checks = 0;
    int sev_cnt = 0;

    // free-running clock at 100 MHz
    always #5 clk = ~clk;

    mcq_top DUT (.CLOCK_I(clk), .RST_N_I(rst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .CAPTURE_INPUT_I(cap),
        .PHASE_A_INPUT_I(pha), .PHASE_B_INPUT_I(phb),
        .INDEX_INPUT_I(pidx), .SPECIAL_EVENT_O(sev), .IRQ_O(irq));

    mcq_enc_model ENC (.clk_i(clk), .step_i(step), .dir_i(dir),
        .index_i(idx), .phase_a_o(pha), .phase_b_o(phb), .index_o(pidx));

    // counts trigger pulses seen on the output
    always @(posedge clk) begin
        if (sev === 1'b1) sev_cnt <= sev_cnt + 1;
    end

    // ==========================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin @(posedge clk); end while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do begin @(posedge clk); end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(posedge clk); end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin @(posedge clk); end while (rvalid !== 1'b1);
        rdv = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        rd(a);
        chk(nm, e, rdv);
    endtask : rd_chk

    task automatic pulse(input int ch);
        @(posedge clk);
        cap[ch] <= 1'b1;
        cyc(12);
        cap[ch] <= 1'b0;
        cyc(12);
    endtask : pulse

    task automatic enc(input logic d, input int n);
        repeat (n) begin
            @(posedge clk);
            dir <= d;
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            cyc(4);
        end
        cyc(4);
    endtask : enc

    // ==========================================
    // scenarios
    task automatic t_regs();
        rd_chk("limit reset", OFF_POS_LIMIT, 32'h0000ffff);
        wstrb <= 4'h1;
        wr(OFF_POS_LIMIT, 32'h1234);
        wstrb <= 4'hf;
        rd_chk("limit byte", OFF_POS_LIMIT, 32'h0000ff34);
        rd(8'h30);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rsp));
        wr(8'h30, 32'h1);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rsp));
        wr(OFF_TB_COUNT, 32'h1234);
        rd_chk("tb read only", OFF_TB_COUNT, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_cap();
        logic [31:0] t1;
        wr(OFF_IRQ_ENABLE, 32'h1);
        wr(OFF_CAP_CTRL, 32'h00010001);
        wr(OFF_TB_CTRL, 32'h1);
        cyc(200);
        pulse(0);
        rd(OFF_TB_COUNT);
        chk("tb cleared", 1, 32'(rdv <= 8));
        rd(OFF_CAP_BUF0);
        chk("first capture", 1, 32'(rdv >= 40));
        chk("irq level", 1, 32'(irq));
        rd_chk("flag one", OFF_IRQ_STATUS, 32'h1);
        cyc(100);
        pulse(0);
        rd(OFF_CAP_BUF0);
        chk("next capture", 1, 32'(rdv >= 25 && rdv <= 45));
        wr(OFF_IRQ_ENABLE, 32'h0);
        cyc(2);
        chk("irq masked", 0, 32'(irq));
        wr(OFF_CAP_CTRL, 32'h10);
        pulse(1);
        rd(OFF_CAP_BUF0 + 8'h04);
        t1 = rdv;
        rd(OFF_TB_COUNT);
        chk("no clear", 1, 32'(rdv >= t1));
        wr(OFF_IRQ_CLEAR, 32'h7);
        wr(OFF_TB_CTRL, 32'h0);
        rd(OFF_TB_COUNT);
        t1 = rdv;
        wr(OFF_CAP_CTRL, 32'h3);
        wr(OFF_CAP_CTRL, 32'h0);
        rd_chk("tb kept", OFF_TB_COUNT, t1);
        // base runs and reset enable is set; modes 1 to 8 must each set the flag, mode 0 must not
        wr(OFF_TB_CTRL, 32'h1);
        for (int m = 0; m <= 8; m++) begin
            wr(OFF_CAP_CTRL, 32'h10000 | 32'(m));
            pulse(0);
            rd_chk("mode flag", OFF_IRQ_STATUS, (m != 0) ? 1 : 0);
            wr(OFF_IRQ_CLEAR, 32'h1);
        end
        $display("test capture done");
    endtask : t_cap

    task automatic t_trig();
        int s0;
        wr(OFF_CAP_CTRL, 32'he0e);
        wr(OFF_TB_CTRL, 32'h1);
        cyc(200);
        wr(OFF_TB_CTRL, 32'h2);
        s0 = sev_cnt;
        pulse(2);
        chk("no trigger", 32'(s0), 32'(sev_cnt));
        pulse(0);
        chk("one trigger", 32'(s0 + 1), 32'(sev_cnt));
        rd_chk("no flag", OFF_IRQ_STATUS, 32'h0);
        rd_chk("run set", OFF_TB_CTRL, 32'h3);
        rd(OFF_TB_COUNT);
        chk("tb restart", 1, 32'(rdv <= 8));
        $display("test trigger done");
    endtask : t_trig

    task automatic t_qei();
        logic [2:0] offs [4] = '{3'h0, 3'h3, 3'h4, 3'h7};
        wr(OFF_QEI_CTRL, 32'(QM_X2_IDX));
        enc(1'b1, 8);
        rd_chk("x2 up", OFF_POS_COUNT, 32'h4);
        rd_chk("dir up", OFF_QEI_CTRL, 32'h21);
        enc(1'b0, 2);
        rd_chk("x2 down", OFF_POS_COUNT, 32'h3);
        rd_chk("dir down", OFF_QEI_CTRL, 32'h01);
        @(posedge clk);
        idx <= 1'b1;
        cyc(6);
        idx <= 1'b0;
        cyc(6);
        rd_chk("index", OFF_POS_COUNT, 32'h0);
        rd_chk("pos flag", OFF_IRQ_STATUS, 32'h8);
        wr(OFF_IRQ_CLEAR, 32'h8);
        wr(OFF_POS_LIMIT, 32'h5);
        wr(OFF_QEI_CTRL, 32'(QM_X4_MAT));
        enc(1'b1, 7);
        rd_chk("x4 wrap", OFF_POS_COUNT, 32'h1);
        rd_chk("match flag", OFF_IRQ_STATUS, 32'h8);
        enc(1'b0, 2);
        rd_chk("x4 under", OFF_POS_COUNT, 32'h5);
        foreach (offs[i]) begin
            wr(OFF_QEI_CTRL, 32'(offs[i]));
            enc(1'b1, 2);
            rd_chk("held", OFF_POS_COUNT, 32'h5);
        end
        $display("test decoder done");
    endtask : t_qei

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // ==========================================
    // main sequence and watchdog
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        t_regs();
        t_cap();
        t_trig();
        t_qei();
        finish_test();
    end

    initial begin
        cyc(20000);
        fail_count++;
        finish_test();
    end
endmodule : mcq_top_tb
